// File: common/rcp_regs.svh
// Constants of the reader host command port
`ifndef RCP_REGS_SVH
`define RCP_REGS_SVH

// Serial link timing
`define RCP_CLK_HZ      100000000
`define RCP_BAUD_HZ     9600
`define RCP_FRAME_BITS  4'hA
`define RCP_DATA_LAST   3'h7

// Characters
`define RCP_CH_SOM      8'h23
`define RCP_CH_CR       8'h0D
`define RCP_CH_LF       8'h0A
`define RCP_CH_ZERO     8'h30
`define RCP_CH_HEXA     8'h37
`define RCP_CH_M        8'h4D

// Command codes as {digit count, digits}
`define RCP_CMD_CMDMODE {3'h2, 24'h000001}
`define RCP_CMD_DATA    {3'h2, 24'h000000}
`define RCP_CMD_VER     {3'h3, 24'h000505}
`define RCP_CMD_RFON    {3'h4, 24'h006401}
`define RCP_CMD_ALLID   {3'h2, 24'h000040}
`define RCP_CMD_AUXON   {3'h3, 24'h000311}
`define RCP_CMD_AUXOFF  {3'h3, 24'h000310}
`define RCP_CMD_MAXLEN  3'h6

// Message texts and last character indices
`define RCP_TXT_MODEL   "Model RDR Ver 1.00 SN"
`define RCP_TXT_BOOT    "Model BOOT Ver 0.00 A"
`define RCP_TXT_DONE    "#Done"
`define RCP_TXT_LAST    5'h14
`define RCP_DONE_LAST   5'h04
`define RCP_SN_LAST     5'h05
`define RCP_HEX_LAST    5'h07
`define RCP_AUX_LAST    5'h01

`endif

// File: common/rcp_pkg.sv
// Types of the reader host command port
package rcp_pkg;
	typedef struct packed {
		logic [31:0] id;
		logic [7:0]  aux;
	} rcp_tag_t;

	typedef enum logic [3:0] {
		RX_IDLE  = 4'h1,
		RX_START = 4'h2,
		RX_DATA  = 4'h4,
		RX_STOP  = 4'h8
	} rcp_rx_t;

	typedef enum logic [1:0] {
		P_IDLE = 2'h1,
		P_COLL = 2'h2
	} rcp_prs_t;

	typedef enum logic [7:0] {
		PH_IDLE = 8'h01,
		PH_HASH = 8'h02,
		PH_TEXT = 8'h04,
		PH_SN   = 8'h08,
		PH_HEX  = 8'h10,
		PH_AUX  = 8'h20,
		PH_CR   = 8'h40,
		PH_LF   = 8'h80
	} rcp_phase_t;

	typedef enum logic [4:0] {
		MSG_SIGNON = 5'h01,
		MSG_BOOT   = 5'h02,
		MSG_DONE   = 5'h04,
		MSG_VER    = 5'h08,
		MSG_TAG    = 5'h10
	} rcp_msg_t;
endpackage

// File: src/rcp_fifo.sv
// Tag report FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module rcp_fifo #(
	parameter int WIDTH = 40,
	parameter int DEPTH = 4,
	localparam int AW = $clog2(DEPTH)
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Fill side
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wp;
	logic [AW-1:0]    rp;
	logic [AW-1:0]    next_wp;
	logic [AW-1:0]    next_rp;
	logic [AW:0]      cnt;
	logic [AW:0]      next_cnt;
	logic             next_in_ready;
	logic             push;
	logic             pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_valid = cnt != '0;
	assign out_data = mem[rp];

	always_comb begin
		next_wp = wp;
		next_rp = rp;
		next_cnt = cnt;
		if (push) begin
			next_wp = (wp == AW'(DEPTH - 1)) ? '0 : wp + AW'(1);
		end
		if (pop) begin
			next_rp = (rp == AW'(DEPTH - 1)) ? '0 : rp + AW'(1);
		end
		if (push && !pop) begin
			next_cnt = cnt + (AW+1)'(1);
		end else if (pop && !push) begin
			next_cnt = cnt - (AW+1)'(1);
		end
		// Ready is registered so back-pressure reaches the source cleanly
		next_in_ready = next_cnt < (AW+1)'(DEPTH);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wp <= '0;
			rp <= '0;
			cnt <= '0;
			in_ready <= 1'b1;
		end else begin
			wp <= next_wp;
			rp <= next_rp;
			cnt <= next_cnt;
			in_ready <= next_in_ready;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp] <= in_data;
		end
	end

	property p_fifo_bound;
		@(posedge clk) disable iff (rst) cnt <= (AW+1)'(DEPTH);
	endproperty
	a_fifo_bound: assert property (p_fifo_bound) else $error("fifo count above depth");

	property p_fifo_full_stall;
		@(posedge clk) disable iff (rst) (cnt == (AW+1)'(DEPTH)) |-> !in_ready;
	endproperty
	a_fifo_full_stall: assert property (p_fifo_full_stall) else $error("fifo ready while full");
endmodule
`default_nettype wire

// File: src/rcp_host_port.sv
// Reader host command port: serial framing, commands, sign-on and tag reports
// Operation
// RULE1: Host uses 9600 baud, 8 data bits, no parity, 1 stop bit.
// RULE2: After power-up send one message: sign-on text or boot failure text.
// RULE3: Sign-on serial number is six digits; all zeros is reported invalid.
// RULE4: Failed checksum reports boot version 0.00 without serial, then download mode.
// RULE5: Commands begin with the start character and end with carriage return.
// RULE6: Code 01 enters command mode and answers the done text with CR LF.
// RULE7: Code 505 answers model, version and serial number with CR LF.
// RULE8: Code 00 returns to data mode and answers the done text with CR LF.
// RULE9: Sequence 01, 6401, 40, 00 leaves the transmitter on continuously.
// RULE10: Data mode sends each read tag as its own report, one after another.
// RULE11: Code 311 appends auxiliary data to reports, 310 removes it; off at reset.
// RULE12: In Wiegand mode commands still arrive over the serial link.
// RULE13: Code 40 disables the uniqueness check so every tag is reported.
// RULE14: Discard characters until start character; a new start restarts the line.
`timescale 1ns/1ps
`default_nettype none
`include "rcp_regs.svh"
module rcp_host_port
	import rcp_pkg::*;
#(
	parameter int BAUD_DIV = `RCP_CLK_HZ / `RCP_BAUD_HZ,
	parameter int FIFO_DEPTH = 4
) (
	// Clock and reset
	input  wire logic       CLK,
	input  wire logic       RST,
	// Serial link
	input  wire logic       UART_RX,
	output logic            UART_TX,
	// Boot status and identity
	input  wire logic       CSUM_OK,
	input  wire logic [23:0] SERIAL_BCD,
	// Tag reports from the decoder
	input  wire logic       TAG_VALID,
	output logic            TAG_READY,
	input  wire rcp_tag_t   TAG_IN,
	// Mode outputs
	output logic            CMD_MODE,
	output logic            RF_ON,
	output logic            AUX_EN,
	output logic            UNIQUE_EN,
	output logic            DOWNLOAD,
	output logic            SN_INVALID
);
	localparam logic [15:0] DIV_M1 = 16'(BAUD_DIV - 1);
	localparam logic [15:0] DIV_HALF = 16'(BAUD_DIV / 2);
	localparam logic [8*21-1:0] TXT_MODEL = `RCP_TXT_MODEL;
	localparam logic [8*21-1:0] TXT_BOOT = `RCP_TXT_BOOT;
	localparam logic [8*5-1:0] TXT_DONE = `RCP_TXT_DONE;

	function automatic logic [7:0] hex_char(input logic [3:0] n);
		hex_char = (n < 4'hA) ? `RCP_CH_ZERO + 8'(n) : `RCP_CH_HEXA + 8'(n);
	endfunction

	// Receive synchroniser and deframer
	logic        rx_s1;
	logic        rx_s2;
	rcp_rx_t     rx_st;
	rcp_rx_t     next_rx_st;
	logic [15:0] rx_cnt;
	logic [15:0] next_rx_cnt;
	logic [2:0]  rx_bit;
	logic [2:0]  next_rx_bit;
	logic [7:0]  rx_byte;
	logic [7:0]  next_rx_byte;
	logic        rx_stb;
	logic        next_rx_stb;

	always_comb begin
		next_rx_st = rx_st;
		next_rx_cnt = (rx_cnt != '0) ? rx_cnt - 16'h0001 : rx_cnt;
		next_rx_bit = rx_bit;
		next_rx_byte = rx_byte;
		next_rx_stb = 1'b0;
		case (rx_st)
			RX_IDLE: begin
				if (!rx_s2) begin
					next_rx_st = RX_START;
					next_rx_cnt = DIV_HALF;
				end
			end
			RX_START: begin
				if (rx_cnt == '0) begin
					next_rx_st = rx_s2 ? RX_IDLE : RX_DATA;
					next_rx_cnt = DIV_M1;
					next_rx_bit = '0;
				end
			end
			RX_DATA: begin
				if (rx_cnt == '0) begin
					next_rx_byte = {rx_s2, rx_byte[7:1]};
					next_rx_bit = rx_bit + 3'h1;
					next_rx_cnt = DIV_M1;
					if (rx_bit == `RCP_DATA_LAST) begin
						next_rx_st = RX_STOP;
					end
				end
			end
			RX_STOP: begin
				if (rx_cnt == '0) begin
					// A low stop bit is a framing error and the byte is dropped
					next_rx_stb = rx_s2; // RULE1
					next_rx_st = RX_IDLE;
				end
			end
			default: next_rx_st = RX_IDLE;
		endcase
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
			rx_st <= RX_IDLE;
			rx_cnt <= '0;
			rx_bit <= '0;
			rx_byte <= '0;
			rx_stb <= 1'b0;
		end else begin
			rx_s1 <= UART_RX;
			rx_s2 <= rx_s1;
			rx_st <= next_rx_st;
			rx_cnt <= next_rx_cnt;
			rx_bit <= next_rx_bit;
			rx_byte <= next_rx_byte;
			rx_stb <= next_rx_stb;
		end
	end

	// Command line parser
	rcp_prs_t    p_st;
	rcp_prs_t    next_p_st;
	logic [23:0] digits;
	logic [23:0] next_digits;
	logic [2:0]  dcnt;
	logic [2:0]  next_dcnt;
	logic        ovf;
	logic        next_ovf;
	logic        cmd_hit;
	logic [26:0] code;

	assign code = {dcnt, digits};
	assign cmd_hit = rx_stb && (p_st == P_COLL) && (rx_byte == `RCP_CH_CR) && !ovf && !DOWNLOAD;

	always_comb begin
		next_p_st = p_st;
		next_digits = digits;
		next_dcnt = dcnt;
		next_ovf = ovf;
		if (rx_stb) begin
			case (p_st)
				P_IDLE: begin
					if (rx_byte == `RCP_CH_SOM) begin // RULE5 RULE14
						next_p_st = P_COLL;
						next_digits = '0;
						next_dcnt = '0;
						next_ovf = 1'b0;
					end
				end
				P_COLL: begin
					if (rx_byte == `RCP_CH_SOM) begin // RULE14
						next_digits = '0;
						next_dcnt = '0;
						next_ovf = 1'b0;
					end else if (rx_byte == `RCP_CH_CR) begin // RULE5
						next_p_st = P_IDLE;
					end else if (dcnt == `RCP_CMD_MAXLEN) begin
						next_ovf = 1'b1;
					end else begin
						next_digits = {digits[19:0], rx_byte[3:0]};
						next_dcnt = dcnt + 3'h1;
					end
				end
				default: next_p_st = P_IDLE;
			endcase
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			p_st <= P_IDLE;
			digits <= '0;
			dcnt <= '0;
			ovf <= 1'b0;
		end else begin
			p_st <= next_p_st;
			digits <= next_digits;
			dcnt <= next_dcnt;
			ovf <= next_ovf;
		end
	end

	// Tag FIFO
	rcp_tag_t   fifo_data;
	logic       fifo_valid;
	logic       fifo_pop;

	rcp_fifo #(
		.WIDTH ($bits(rcp_tag_t)),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (CLK),
		.rst       (RST),
		.in_valid  (TAG_VALID),
		.in_ready  (TAG_READY),
		.in_data   (TAG_IN),
		.out_valid (fifo_valid),
		.out_ready (fifo_pop),
		.out_data  (fifo_data)
	);

	// Message emitter and transmitter
	rcp_phase_t  ph;
	rcp_phase_t  next_ph;
	rcp_msg_t    kind;
	rcp_msg_t    next_kind;
	logic [4:0]  idx;
	logic [4:0]  next_idx;
	rcp_tag_t    tag_q;
	rcp_tag_t    next_tag_q;
	logic [31:0] last_id;
	logic [31:0] next_last_id;
	logic        have_last;
	logic        next_have_last;
	logic        boot_pend;
	logic        next_boot_pend;
	logic        resp_done;
	logic        next_resp_done;
	logic        resp_ver;
	logic        next_resp_ver;
	logic        next_cmd_mode;
	logic        next_rf_on;
	logic        next_aux_en;
	logic        next_unique_en;
	logic        next_download;
	logic [9:0]  tx_sh;
	logic [9:0]  next_tx_sh;
	logic [15:0] tx_cnt;
	logic [15:0] next_tx_cnt;
	logic [3:0]  tx_bits;
	logic [3:0]  next_tx_bits;
	logic        tx_load;
	logic        next_sn_invalid;
	logic [7:0]  cur_char;
	logic [4:0]  last_idx;
	logic        first_tx;
	logic        next_first_tx;

	assign tx_load = (ph != PH_IDLE) && (tx_bits == '0);
	assign UART_TX = tx_sh[0];
	// Pending replies already hold tags back, so no loop through the emitter is needed
	assign fifo_pop = (ph == PH_IDLE) && !DOWNLOAD && !boot_pend
		&& !resp_ver && !resp_done && !CMD_MODE && fifo_valid; // RULE10

	always_comb begin
		cur_char = `RCP_CH_LF;
		last_idx = '0;
		case (ph)
			PH_HASH: cur_char = `RCP_CH_SOM;
			PH_TEXT: begin
				if (kind == MSG_DONE) begin
					cur_char = TXT_DONE[8*(`RCP_DONE_LAST - idx) +: 8];
					last_idx = `RCP_DONE_LAST;
				end else begin
					cur_char = (kind == MSG_BOOT) ? TXT_BOOT[8*(`RCP_TXT_LAST - idx) +: 8]
						: TXT_MODEL[8*(`RCP_TXT_LAST - idx) +: 8]; // RULE4
					last_idx = `RCP_TXT_LAST;
				end
			end
			PH_SN: begin
				cur_char = `RCP_CH_ZERO + 8'(SERIAL_BCD[4*(`RCP_SN_LAST - idx) +: 4]); // RULE3
				last_idx = `RCP_SN_LAST;
			end
			PH_HEX: begin
				cur_char = hex_char(tag_q.id[4*(`RCP_HEX_LAST - idx) +: 4]);
				last_idx = `RCP_HEX_LAST;
			end
			PH_AUX: begin
				cur_char = hex_char(tag_q.aux[4*(`RCP_AUX_LAST - idx) +: 4]);
				last_idx = `RCP_AUX_LAST;
			end
			PH_CR: cur_char = `RCP_CH_CR;
			default: cur_char = `RCP_CH_LF;
		endcase
	end

	always_comb begin
		next_ph = ph;
		next_kind = kind;
		next_idx = idx;
		next_tag_q = tag_q;
		next_last_id = last_id;
		next_have_last = have_last;
		next_boot_pend = boot_pend;
		next_resp_done = resp_done;
		next_resp_ver = resp_ver;
		next_cmd_mode = CMD_MODE;
		next_rf_on = RF_ON;
		next_aux_en = AUX_EN;
		next_unique_en = UNIQUE_EN;
		next_download = DOWNLOAD;
		next_sn_invalid = SERIAL_BCD == '0; // RULE3
		next_first_tx = first_tx && !tx_load;
		if (ph == PH_IDLE && !DOWNLOAD) begin
			if (boot_pend) begin
				// Checksum level is caught on the first clock after reset release
				next_boot_pend = 1'b0;
				next_kind = CSUM_OK ? MSG_SIGNON : MSG_BOOT; // RULE2 RULE4
				next_ph = PH_TEXT;
			end else if (resp_ver) begin
				next_resp_ver = 1'b0;
				next_kind = MSG_VER;
				next_ph = PH_HASH; // RULE7
			end else if (resp_done) begin
				next_resp_done = 1'b0;
				next_kind = MSG_DONE;
				next_ph = PH_TEXT;
			end else if (fifo_pop) begin
				if (!(UNIQUE_EN && have_last && fifo_data.id == last_id)) begin // RULE13
					next_kind = MSG_TAG;
					next_ph = PH_HEX; // RULE10
					next_tag_q = fifo_data;
					next_last_id = fifo_data.id;
					next_have_last = 1'b1;
				end
			end
			next_idx = '0;
		end else if (tx_load) begin
			next_idx = idx + 5'h01;
			if (idx == last_idx) begin
				next_idx = '0;
				case (ph)
					PH_HASH: next_ph = PH_TEXT;
					PH_TEXT: next_ph = (kind == MSG_SIGNON || kind == MSG_VER) ? PH_SN : PH_CR;
					PH_SN: next_ph = PH_CR;
					PH_HEX: next_ph = AUX_EN ? PH_AUX : PH_CR; // RULE11
					PH_AUX: next_ph = PH_CR;
					PH_CR: next_ph = PH_LF;
					PH_LF: begin
						next_ph = PH_IDLE;
						if (kind == MSG_BOOT) begin
							next_download = 1'b1; // RULE4
						end
					end
					default: next_ph = PH_IDLE;
				endcase
			end
		end
		if (cmd_hit) begin
			if (code == `RCP_CMD_CMDMODE) begin
				next_cmd_mode = 1'b1; // RULE6
				next_resp_done = 1'b1;
			end else if (code == `RCP_CMD_DATA) begin
				next_cmd_mode = 1'b0; // RULE8
				next_resp_done = 1'b1;
			end else if (CMD_MODE) begin
				case (code)
					`RCP_CMD_VER: next_resp_ver = 1'b1; // RULE7
					`RCP_CMD_RFON: next_rf_on = 1'b1; // RULE9
					`RCP_CMD_ALLID: next_unique_en = 1'b0; // RULE13 RULE9
					`RCP_CMD_AUXON: next_aux_en = 1'b1; // RULE11
					`RCP_CMD_AUXOFF: next_aux_en = 1'b0; // RULE11
					default: next_aux_en = AUX_EN;
				endcase
			end
		end
	end

	always_comb begin
		next_tx_sh = tx_sh;
		next_tx_cnt = tx_cnt;
		next_tx_bits = tx_bits;
		if (tx_load) begin
			next_tx_sh = {1'b1, cur_char, 1'b0}; // RULE1
			next_tx_cnt = DIV_M1;
			next_tx_bits = `RCP_FRAME_BITS;
		end else if (tx_bits != '0) begin
			if (tx_cnt == '0) begin
				next_tx_sh = {1'b1, tx_sh[9:1]};
				next_tx_cnt = DIV_M1;
				next_tx_bits = tx_bits - 4'h1;
			end else begin
				next_tx_cnt = tx_cnt - 16'h0001;
			end
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ph <= PH_IDLE;
			kind <= MSG_SIGNON;
			idx <= '0;
			tag_q <= '0;
			last_id <= '0;
			have_last <= 1'b0;
			boot_pend <= 1'b1;
			resp_done <= 1'b0;
			resp_ver <= 1'b0;
			CMD_MODE <= 1'b0;
			RF_ON <= 1'b0;
			AUX_EN <= 1'b0;
			UNIQUE_EN <= 1'b1;
			DOWNLOAD <= 1'b0;
			SN_INVALID <= 1'b0;
			tx_sh <= 10'h3FF;
			tx_cnt <= '0;
			tx_bits <= '0;
			first_tx <= 1'b1;
		end else begin
			ph <= next_ph;
			kind <= next_kind;
			idx <= next_idx;
			tag_q <= next_tag_q;
			last_id <= next_last_id;
			have_last <= next_have_last;
			boot_pend <= next_boot_pend;
			resp_done <= next_resp_done;
			resp_ver <= next_resp_ver;
			CMD_MODE <= next_cmd_mode;
			RF_ON <= next_rf_on;
			AUX_EN <= next_aux_en;
			UNIQUE_EN <= next_unique_en;
			DOWNLOAD <= next_download;
			SN_INVALID <= next_sn_invalid;
			tx_sh <= next_tx_sh;
			tx_cnt <= next_tx_cnt;
			tx_bits <= next_tx_bits;
			first_tx <= next_first_tx;
		end
	end

	sequence s_hit(logic [26:0] c);
		cmd_hit && code == c;
	endsequence

	property p_first_msg;
		@(posedge CLK) disable iff (RST) (tx_load && first_tx) |-> cur_char == `RCP_CH_M;
	endproperty
	a_first_msg: assert property (p_first_msg) else $error("first message not sign-on"); // RULE2

	property p_sn_invalid;
		@(posedge CLK) disable iff (RST) (SERIAL_BCD == '0) ##1 (SERIAL_BCD == '0) |-> SN_INVALID;
	endproperty
	a_sn_invalid: assert property (p_sn_invalid) else $error("zero serial not flagged"); // RULE3

	property p_download;
		@(posedge CLK) disable iff (RST) (tx_load && ph == PH_LF && kind == MSG_BOOT) |=> DOWNLOAD;
	endproperty
	a_download: assert property (p_download) else $error("no download after boot failure"); // RULE4

	property p_som_gate;
		@(posedge CLK) disable iff (RST)
			(p_st == P_IDLE && rx_stb && rx_byte != `RCP_CH_SOM) |=> p_st == P_IDLE;
	endproperty
	a_som_gate: assert property (p_som_gate) else $error("line opened without start"); // RULE5

	property p_cmd_mode;
		@(posedge CLK) disable iff (RST) s_hit(`RCP_CMD_CMDMODE) |=> CMD_MODE && resp_done;
	endproperty
	a_cmd_mode: assert property (p_cmd_mode) else $error("01 not handled"); // RULE6

	property p_ver;
		@(posedge CLK) disable iff (RST) (s_hit(`RCP_CMD_VER) and CMD_MODE) |=> resp_ver;
	endproperty
	a_ver: assert property (p_ver) else $error("505 not answered"); // RULE7

	property p_data_mode;
		@(posedge CLK) disable iff (RST) s_hit(`RCP_CMD_DATA) |=> !CMD_MODE && resp_done;
	endproperty
	a_data_mode: assert property (p_data_mode) else $error("00 not handled"); // RULE8

	property p_rf_hold;
		@(posedge CLK) disable iff (RST) RF_ON |=> RF_ON;
	endproperty
	a_rf_hold: assert property (p_rf_hold) else $error("rf dropped"); // RULE9

	property p_tag_data;
		@(posedge CLK) disable iff (RST) (ph == PH_IDLE ##1 ph == PH_HEX) |-> !$past(CMD_MODE);
	endproperty
	a_tag_data: assert property (p_tag_data) else $error("tag report in command mode"); // RULE10

	property p_aux;
		@(posedge CLK) disable iff (RST)
			(s_hit(`RCP_CMD_AUXON) and CMD_MODE) |=> AUX_EN;
	endproperty
	a_aux: assert property (p_aux) else $error("311 not applied"); // RULE11

	property p_all_id;
		@(posedge CLK) disable iff (RST) (s_hit(`RCP_CMD_ALLID) and CMD_MODE) |=> !UNIQUE_EN;
	endproperty
	a_all_id: assert property (p_all_id) else $error("40 not applied"); // RULE13

	property p_restart;
		@(posedge CLK) disable iff (RST)
			(p_st == P_COLL && rx_stb && rx_byte == `RCP_CH_SOM) |=> p_st == P_COLL && dcnt == '0;
	endproperty
	a_restart: assert property (p_restart) else $error("start did not restart line"); // RULE14
endmodule
`default_nettype wire

// File: dv/rcp_host_model.sv
// Host terminal model: 8N1 sender and receiver on the serial link
`timescale 1ns/1ps
`default_nettype none
`include "rcp_regs.svh"
module rcp_host_model #(
	parameter int DIV = 16
) (
	// Clock
	input  wire logic clk,
	// Serial lines
	input  wire logic line_in,
	output logic      line_out
);
	logic [7:0] rx_q[$];
	logic [7:0] b;

	initial line_out = 1'b1;

	task automatic send_byte(input logic [7:0] c);
		logic [9:0] f;
		f = {1'b1, c, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(negedge clk);
			line_out = f[i];
			repeat (DIV - 1) @(negedge clk);
		end
	endtask

	task automatic send_str(input string s);
		for (int i = 0; i < s.len(); i++) begin
			send_byte(s[i]);
		end
	endtask

	// Commands always travel over the serial link, framed by start and CR
	task automatic send_cmd(input string s);
		send_byte(`RCP_CH_SOM);
		send_str(s);
		send_byte(`RCP_CH_CR);
	endtask

	// Receiver samples mid-bit and keeps only bytes with a high stop bit
	always begin
		@(negedge line_in);
		repeat (DIV / 2) @(posedge clk);
		if (line_in === 1'b0) begin
			for (int i = 0; i < 8; i++) begin
				repeat (DIV) @(posedge clk);
				b[i] = line_in;
			end
			repeat (DIV) @(posedge clk);
			if (line_in === 1'b1) begin
				rx_q.push_back(b);
			end
		end
	end
endmodule
`default_nettype wire

// File: dv/test_reader_host_command_port.sv
// Testbench of the reader host command port
`timescale 1ns/1ps
`default_nettype none
`include "rcp_regs.svh"
module test_reader_host_command_port
	import rcp_pkg::*;
;
	localparam int DIV = 16;
	logic        clk;
	logic        rst;
	logic        rxd;
	logic        txd;
	logic        csum_ok;
	logic [23:0] serial_bcd;
	logic        tag_valid;
	logic        tag_ready;
	rcp_tag_t    tag_in;
	logic        cmd_mode;
	logic        rf_on;
	logic        aux_en;
	logic        unique_en;
	logic        download;
	logic        sn_invalid;
	int          n_fail;
	int          n_checks;
	int          cyc = 0;
	logic [31:0] seed;
	logic [7:0]  exp_q[$];
	rcp_tag_t    ta;
	rcp_tag_t    tb[5];

	rcp_host_port #(.BAUD_DIV(DIV), .FIFO_DEPTH(4)) u_dut (
		.CLK(clk), .RST(rst), .UART_RX(rxd), .UART_TX(txd), .CSUM_OK(csum_ok),
		.SERIAL_BCD(serial_bcd), .TAG_VALID(tag_valid), .TAG_READY(tag_ready),
		.TAG_IN(tag_in), .CMD_MODE(cmd_mode), .RF_ON(rf_on), .AUX_EN(aux_en),
		.UNIQUE_EN(unique_en), .DOWNLOAD(download), .SN_INVALID(sn_invalid)
	);
	rcp_host_model #(.DIV(DIV)) u_host (.clk(clk), .line_in(txd), .line_out(rxd));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [7:0] hx(input logic [3:0] n);
		return (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
	endfunction

	task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic stop_test();
		if (n_fail == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic add_line(input string s, input logic eol);
		for (int i = 0; i < s.len(); i++) begin
			exp_q.push_back(s[i]);
		end
		if (eol) begin
			exp_q.push_back(`RCP_CH_CR);
			exp_q.push_back(`RCP_CH_LF);
		end
	endtask

	task automatic add_sn(input logic [23:0] s);
		for (int i = 5; i >= 0; i--) begin
			exp_q.push_back(`RCP_CH_ZERO + {4'h0, s[i*4+:4]});
		end
		add_line("", 1'b1);
	endtask

	task automatic add_tag(input rcp_tag_t t, input logic aux);
		for (int i = 7; i >= 0; i--) begin
			exp_q.push_back(hx(t.id[i*4+:4]));
		end
		if (aux) begin
			exp_q.push_back(hx(t.aux[7:4]));
			exp_q.push_back(hx(t.aux[3:0]));
		end
		add_line("", 1'b1);
	endtask

	// Compare every expected byte in order against what the host received
	task automatic expect_all();
		int w;
		logic [7:0] b;
		while (exp_q.size() > 0) begin
			w = 0;
			while (u_host.rx_q.size() == 0 && w < 4000) begin
				@(posedge clk);
				w++;
			end
			b = (u_host.rx_q.size() > 0) ? u_host.rx_q.pop_front() : 8'hXX;
			check("reply byte", {32'h0, b}, {32'h0, exp_q.pop_front()});
		end
	endtask

	task automatic quiet();
		repeat (30 * DIV) @(negedge clk);
		check("spare bytes", 40'(u_host.rx_q.size()), 40'h0);
	endtask

	task automatic push(input rcp_tag_t t);
		int w;
		tag_in = t;
		tag_valid = 1'b1;
		w = 0;
		while (tag_ready !== 1'b1 && w < 6000) begin
			@(negedge clk);
			w++;
		end
		@(negedge clk);
	endtask

	task automatic do_reset();
		@(negedge clk);
		rst = 1'b1;
		repeat (5) @(negedge clk);
		check("reset outputs", 40'({txd, tag_ready, cmd_mode, rf_on, aux_en, unique_en,
			download, sn_invalid}), 40'h000000C4);
		u_host.rx_q.delete();
		rst = 1'b0;
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			n_fail++;
			stop_test();
		end
	end

	initial begin
		n_fail = 0;
		n_checks = 0;
		seed = 32'hdfa0;
		rst = 1'b1;
		csum_ok = 1'b0;
		serial_bcd = 24'h000000;
		tag_valid = 1'b0;
		tag_in = '0;
		// Failed checksum: boot text, download mode, commands ignored
		do_reset();
		add_line(`RCP_TXT_BOOT, 1'b1);
		expect_all();
		repeat (2 * DIV) @(negedge clk);
		check("download", 40'(download), 40'h1);
		u_host.send_cmd("01");
		quiet();
		check("cmd mode", 40'(cmd_mode), 40'h0);
		// Good checksum with an unstored serial number
		csum_ok = 1'b1;
		do_reset();
		add_line(`RCP_TXT_MODEL, 1'b0);
		add_sn(24'h000000);
		expect_all();
		check("sn invalid", 40'(sn_invalid), 40'h1);
		@(negedge clk);
		for (int i = 0; i < 6; i++) begin
			serial_bcd[i*4+:4] = 4'(rnd() % 10);
		end
		// Repeat of the last reported id is dropped while uniqueness is on
		ta.id = rnd();
		ta.aux = 8'(rnd());
		tb[0] = ta;
		tb[0].id = ta.id ^ 32'h00000001;
		@(negedge clk);
		push(ta);
		push(ta);
		push(tb[0]);
		tag_valid = 1'b0;
		add_tag(ta, 1'b0);
		add_tag(tb[0], 1'b0);
		expect_all();
		check("sn invalid", 40'(sn_invalid), 40'h0);
		u_host.send_cmd("311");
		quiet();
		check("aux in data mode", 40'(aux_en), 40'h0);
		u_host.send_str("x9#0");
		u_host.send_cmd("01");
		add_line(`RCP_TXT_DONE, 1'b1);
		expect_all();
		check("cmd mode", 40'(cmd_mode), 40'h1);
		u_host.send_cmd("505");
		add_line("#", 1'b0);
		add_line(`RCP_TXT_MODEL, 1'b0);
		add_sn(serial_bcd);
		expect_all();
		u_host.send_cmd("311");
		u_host.send_cmd("6401");
		u_host.send_cmd("40");
		u_host.send_cmd("00");
		add_line(`RCP_TXT_DONE, 1'b1);
		expect_all();
		check("modes", 40'({cmd_mode, aux_en, rf_on, unique_en}), 40'h6);
		// Fill the FIFO back to back; repeats now pass and carry aux
		tb[1] = tb[0];
		for (int i = 2; i < 5; i++) begin
			tb[i].id = rnd();
			tb[i].aux = 8'(rnd());
		end
		@(negedge clk);
		for (int i = 0; i < 5; i++) begin
			push(tb[i]);
		end
		check("fifo full", 40'(tag_ready), 40'h0);
		tag_valid = 1'b0;
		for (int i = 0; i < 5; i++) begin
			add_tag(tb[i], 1'b1);
		end
		expect_all();
		u_host.send_cmd("01");
		u_host.send_cmd("310");
		u_host.send_cmd("00");
		add_line(`RCP_TXT_DONE, 1'b1);
		add_line(`RCP_TXT_DONE, 1'b1);
		expect_all();
		check("aux off", 40'(aux_en), 40'h0);
		stop_test();
	end
endmodule
`default_nettype wire
